// ==== iq_interp_pkg.sv ====
package iq_interp_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int IN_W = 12;          // Input sample width
    localparam int DATA_W = 16;        // Internal sample width
    localparam int IN_SHIFT = 4;       // Input alignment to internal width
    localparam int COEF_W = 16;        // Coefficient width
    localparam int COEF_FRAC = 15;     // Coefficient fraction bits
    localparam int ACC_W = 40;         // Accumulator width
    localparam int RATIO_W = 6;        // CIC ratio field width
    localparam int SHIFT_W = 5;        // CIC output scaling shift width
    localparam int SUB_W = 3;          // Half-band phase counter width

    // ------------------------------------------------------------
    // CIC constants
    // ------------------------------------------------------------
    localparam int CIC_ORDER = 4;                      // Number of comb and integrator sections
    localparam logic [RATIO_W-1:0] RATIO_MIN = 6'h02;  // Lowest legal ratio
    localparam logic [RATIO_W-1:0] RATIO_RST = 6'h02;  // Ratio SHIFT_RST is matched to; the chain runs at cic_ratio
    localparam logic [SHIFT_W-1:0] SHIFT_RST = 5'h03;  // Scaling shift for reset ratio
    localparam int SHIFT_SEARCH = 24;                  // Shift search span

    // ------------------------------------------------------------
    // Half-band coefficients, one side of the odd phase, tap 0 innermost
    // ------------------------------------------------------------
    localparam int HB1_SIDE = 12;      // 47 taps
    localparam int HB2_SIDE = 4;       // 15 taps
    localparam int HB3_SIDE = 3;       // 11 taps
    localparam logic [HB1_SIDE*COEF_W-1:0] HB1_COEF = {
        16'hFFB4, 16'h00FA, 16'hFEF2, 16'h01AE, 16'hFD76, 16'h03B6,
        16'hFABA, 16'h076C, 16'hF574, 16'h0FA0, 16'hE50C, 16'h5140};
    localparam logic [HB2_SIDE*COEF_W-1:0] HB2_COEF = {
        16'hFF28, 16'h04B0, 16'hF0C4, 16'h4B64};
    localparam logic [HB3_SIDE*COEF_W-1:0] HB3_COEF = {
        16'h02AC, 16'hF0C4, 16'h4C90};

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic signed [IN_W-1:0] i;     // In-phase input sample
        logic signed [IN_W-1:0] q;     // Quadrature input sample
    } pair_in_t;

    typedef struct packed {
        logic signed [DATA_W-1:0] i;   // In-phase output sample
        logic signed [DATA_W-1:0] q;   // Quadrature output sample
    } pair_out_t;

    // Clamp a wide value to the internal sample range
    function automatic logic signed [DATA_W-1:0] sat_data(input logic signed [ACC_W-1:0] v);
        logic signed [ACC_W-1:0] hi;
        logic signed [ACC_W-1:0] lo;
        hi = ACC_W'(32767);
        lo = -ACC_W'(32768);
        if (v > hi) begin
            sat_data = 16'h7FFF;
        end else if (v < lo) begin
            sat_data = 16'h8000;
        end else begin
            sat_data = v[DATA_W-1:0];
        end
    endfunction : sat_data

endpackage : iq_interp_pkg

// ==== iq_interpolation_filter_chain.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Half-band interpolator by two, polyphase form
// ----------------------------------------------------------------
module halfband_interp #(
    parameter int SIDE = 3,
    parameter logic [SIDE*iq_interp_pkg::COEF_W-1:0] COEF = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Rate enables
    input wire logic in_en,
    input wire logic out_en,
    // Samples
    input wire logic signed [iq_interp_pkg::DATA_W-1:0] din,
    output logic signed [iq_interp_pkg::DATA_W-1:0] dout
);
    // Delay line of input samples
    logic signed [iq_interp_pkg::DATA_W-1:0] tap_reg [2*SIDE];
    // Odd phase result
    logic signed [iq_interp_pkg::DATA_W-1:0] odd_val;

    // Shift a new sample in at the input rate
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < 2*SIDE; k++) begin
                tap_reg[k] <= '0;
            end
        end else if (in_en) begin
            tap_reg[0] <= din;
            for (int k = 1; k < 2*SIDE; k++) begin
                tap_reg[k] <= tap_reg[k-1];
            end
        end
    end

    // Odd phase: mirrored taps added before one multiply each
    always_comb begin
        logic signed [iq_interp_pkg::ACC_W-1:0] acc;
        logic signed [iq_interp_pkg::DATA_W:0] pair_sum;
        logic signed [iq_interp_pkg::COEF_W-1:0] c;
        acc = iq_interp_pkg::ACC_W'(1 <<< (iq_interp_pkg::COEF_FRAC - 1));
        pair_sum = '0;
        c = '0;
        for (int k = 0; k < SIDE; k++) begin
            c = COEF[k*iq_interp_pkg::COEF_W +: iq_interp_pkg::COEF_W];
            pair_sum = 17'(tap_reg[SIDE-1-k]) + 17'(tap_reg[SIDE+k]);
            acc = acc + iq_interp_pkg::ACC_W'(c * pair_sum);
        end
        odd_val = iq_interp_pkg::sat_data(acc >>> iq_interp_pkg::COEF_FRAC);
    end

    // Two outputs per input: centre sample, then the midpoint
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout <= '0;
        end else if (out_en) begin
            if (in_en) begin
                dout <= odd_val;       // Midpoint before next shift
            end else begin
                dout <= tap_reg[SIDE]; // Centre sample
            end
        end
    end
endmodule : halfband_interp

// ----------------------------------------------------------------
// Fourth-order CIC interpolator
// ----------------------------------------------------------------
module cic_interp (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Low-rate enable and scaling
    input wire logic in_en,
    input wire logic [iq_interp_pkg::SHIFT_W-1:0] shift,
    // Samples
    input wire logic signed [iq_interp_pkg::DATA_W-1:0] din,
    output logic signed [iq_interp_pkg::DATA_W-1:0] dout
);
    localparam int N = iq_interp_pkg::CIC_ORDER;
    localparam int AW = iq_interp_pkg::ACC_W;

    // Comb chain values and unit delays
    logic signed [AW-1:0] comb_val [N+1];
    logic signed [AW-1:0] comb_dly_reg [N];
    // Last comb result and its one-cycle stuffing pulse
    logic signed [AW-1:0] comb_out_reg;
    logic stuff_reg;
    // Integrator accumulators
    logic signed [AW-1:0] integ_reg [N];

    // Comb sections at the low rate, one delay each
    always_comb begin
        comb_val[0] = AW'(din);
        for (int k = 0; k < N; k++) begin
            comb_val[k+1] = comb_val[k] - comb_dly_reg[k];
        end
    end

    // Update comb delays on each low-rate sample
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < N; k++) begin
                comb_dly_reg[k] <= '0;
            end
            comb_out_reg <= '0;
        end else if (in_en) begin
            for (int k = 0; k < N; k++) begin
                comb_dly_reg[k] <= comb_val[k];
            end
            comb_out_reg <= comb_val[N];
        end
    end

    // Zero stuffing: comb result enters the integrators once per ratio
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stuff_reg <= 1'b0;
        end else begin
            stuff_reg <= in_en;
        end
    end

    // Integrator sections at the full clock rate
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < N; k++) begin
                integ_reg[k] <= '0;
            end
        end else begin
            integ_reg[0] <= integ_reg[0] + (stuff_reg ? comb_out_reg : '0);
            for (int k = 1; k < N; k++) begin
                integ_reg[k] <= integ_reg[k] + integ_reg[k-1];
            end
        end
    end

    // Output scaling by the gain-dependent shift
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout <= '0;
        end else begin
            dout <= iq_interp_pkg::sat_data(integ_reg[N-1] >>> shift);
        end
    end
endmodule : cic_interp

// ----------------------------------------------------------------
// Top: I/Q interpolation chain
// ----------------------------------------------------------------
module iq_interpolation_filter_chain (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Configuration levels
    input wire logic [iq_interp_pkg::RATIO_W-1:0] cic_ratio,
    input wire logic optional_halfband_stage,
    input wire logic comb_stage_double_gain,
    // Assembled pair input
    input wire iq_interp_pkg::pair_in_t pair_in,
    input wire logic pair_valid,
    output logic pair_sample_rate,
    // Interpolated output
    output iq_interp_pkg::pair_out_t out_pair,
    output logic out_valid
);
    // Effective ratio, counters and scaling
    logic [iq_interp_pkg::RATIO_W-1:0] ratio_eff;
    logic [iq_interp_pkg::RATIO_W-1:0] ratio_cnt_reg;
    logic [iq_interp_pkg::SUB_W-1:0] sub_cnt_reg;
    logic [iq_interp_pkg::SHIFT_W-1:0] shift_reg;
    logic [iq_interp_pkg::SHIFT_W-1:0] shift_next;
    logic ratio_tick;
    // Rate ticks: tick[j] fires every ratio * 2^j cycles
    logic [iq_interp_pkg::SUB_W:0] tick;
    // Stage enables
    logic hb1_in_en;
    logic hb1_out_en;
    logic hb2_out_en;
    // Per-lane stage samples, lane 0 is I, lane 1 is Q
    logic signed [iq_interp_pkg::DATA_W-1:0] lane_in [2];
    logic signed [iq_interp_pkg::DATA_W-1:0] lane_out [2];

    // Ratio below the minimum is run at the minimum
    always_comb begin
        if (cic_ratio < iq_interp_pkg::RATIO_MIN) begin
            ratio_eff = iq_interp_pkg::RATIO_MIN;
        end else begin
            ratio_eff = cic_ratio;
        end
    end

    // Divider producing the CIC low-rate tick
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ratio_cnt_reg <= '0;
        end else if (ratio_cnt_reg >= ratio_eff - 6'h01) begin
            ratio_cnt_reg <= '0;
        end else begin
            ratio_cnt_reg <= ratio_cnt_reg + 6'h01;
        end
    end
    assign ratio_tick = (ratio_cnt_reg >= ratio_eff - 6'h01);

    // Half-band phase counter advanced on each low-rate tick
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sub_cnt_reg <= '0;
        end else if (ratio_tick) begin
            sub_cnt_reg <= sub_cnt_reg + 3'h1;
        end
    end

    // Rate ticks, each half the rate of the one before
    generate
        for (genvar j = 0; j <= iq_interp_pkg::SUB_W; j++) begin : g_tick
            if (j == 0) begin : g_base
                assign tick[j] = ratio_tick;
            end else begin : g_div
                assign tick[j] = ratio_tick && (&sub_cnt_reg[j-1:0]);
            end
        end
    endgenerate

    // Stage enables shift up one rate when the optional stage is used
    assign hb2_out_en = optional_halfband_stage ? tick[1] : tick[0];
    assign hb1_out_en = optional_halfband_stage ? tick[2] : tick[1];
    assign hb1_in_en = optional_halfband_stage ? tick[3] : tick[2];
    assign pair_sample_rate = hb1_in_en;

    // Scaling shift: least s with 2^s not below ratio cubed
    always_comb begin
        logic [17:0] cube;
        logic [iq_interp_pkg::SHIFT_W-1:0] s;
        cube = 18'(ratio_eff) * 18'(ratio_eff) * 18'(ratio_eff);
        s = '0;
        for (int b = 0; b < iq_interp_pkg::SHIFT_SEARCH; b++) begin
            if ((40'h1 << b) < 40'(cube)) begin
                s = iq_interp_pkg::SHIFT_W'(b + 1);
            end
        end
        if (comb_stage_double_gain) begin
            shift_next = s - 5'h01;
        end else begin
            shift_next = s;
        end
    end

    // Register the scaling shift
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= iq_interp_pkg::SHIFT_RST;
        end else begin
            shift_reg <= shift_next;
        end
    end

    // Missing pair becomes numerical zero; 12-bit sample placed in the top bits
    always_comb begin
        if (pair_valid) begin
            lane_in[0] = {pair_in.i, {iq_interp_pkg::IN_SHIFT{1'b0}}};
            lane_in[1] = {pair_in.q, {iq_interp_pkg::IN_SHIFT{1'b0}}};
        end else begin
            lane_in[0] = '0;
            lane_in[1] = '0;
        end
    end

    // Two identical lanes sharing every enable
    generate
        for (genvar l = 0; l < 2; l++) begin : g_lane
            logic signed [iq_interp_pkg::DATA_W-1:0] hb1_out;
            logic signed [iq_interp_pkg::DATA_W-1:0] hb2_out;
            logic signed [iq_interp_pkg::DATA_W-1:0] hb3_out;
            logic signed [iq_interp_pkg::DATA_W-1:0] cic_in;

            // First half-band
            halfband_interp #(
                .SIDE(iq_interp_pkg::HB1_SIDE),
                .COEF(iq_interp_pkg::HB1_COEF)
            ) first_halfband_stage (
                .clk(clk),
                .rst_n(rst_n),
                .in_en(hb1_in_en),
                .out_en(hb1_out_en),
                .din(lane_in[l]),
                .dout(hb1_out)
            );

            // Second half-band
            halfband_interp #(
                .SIDE(iq_interp_pkg::HB2_SIDE),
                .COEF(iq_interp_pkg::HB2_COEF)
            ) second_halfband_stage (
                .clk(clk),
                .rst_n(rst_n),
                .in_en(hb1_out_en),
                .out_en(hb2_out_en),
                .din(hb1_out),
                .dout(hb2_out)
            );

            // Optional half-band
            halfband_interp #(
                .SIDE(iq_interp_pkg::HB3_SIDE),
                .COEF(iq_interp_pkg::HB3_COEF)
            ) optional_halfband (
                .clk(clk),
                .rst_n(rst_n),
                .in_en(tick[1]),
                .out_en(tick[0]),
                .din(hb2_out),
                .dout(hb3_out)
            );

            // Bypass the optional stage when unselected
            assign cic_in = optional_halfband_stage ? hb3_out : hb2_out;

            // CIC interpolator
            cic_interp cic (
                .clk(clk),
                .rst_n(rst_n),
                .in_en(ratio_tick),
                .shift(shift_reg),
                .din(cic_in),
                .dout(lane_out[l])
            );
        end
    endgenerate

    // Output pair assembled from both lanes
    assign out_pair.i = lane_out[0];
    assign out_pair.q = lane_out[1];

    // Output strobe: one sample every clock after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
        end else begin
            out_valid <= 1'b1;
        end
    end
endmodule : iq_interpolation_filter_chain

// ==== iq_chain_properties.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// Port checks of the I/Q interpolation chain
// ------------------------------------------------------------
module iq_chain_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Configuration levels
    input wire logic [iq_interp_pkg::RATIO_W-1:0] cic_ratio,
    input wire logic optional_halfband_stage,
    input wire logic comb_stage_double_gain,
    // Pair input
    input wire iq_interp_pkg::pair_in_t pair_in,
    input wire logic pair_valid,
    input wire logic pair_sample_rate,
    // Interpolated output
    input wire iq_interp_pkg::pair_out_t out_pair,
    input wire logic out_valid
);
    logic [10:0] gap_reg;  // Cycles since the last pulse
    logic seen_reg;        // A pulse has been seen
    logic same_reg;        // Every taken pair had equal lanes
    logic zero_reg;        // Every taken pair was zero
    logic [10:0] period;   // Expected pulse spacing

    // Ratio below two acts as two
    // Four or eight CIC low-rate steps, each one CIC ratio long
    assign period = (optional_halfband_stage ? 11'h008 : 11'h004)
        * ((cic_ratio < 6'h02) ? 11'h002 : 11'(cic_ratio));

    // Pulse spacing counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_reg <= 11'h000;
            seen_reg <= 1'b0;
        end else if (pair_sample_rate) begin
            gap_reg <= 11'h000;
            seen_reg <= 1'b1;
        end else if (gap_reg != 11'h7FF) begin
            gap_reg <= gap_reg + 11'h001;
        end
    end

    // History of what the chain has taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            same_reg <= 1'b1;
            zero_reg <= 1'b1;
        end else if (pair_sample_rate && pair_valid) begin
            if (pair_in.i != pair_in.q) begin
                same_reg <= 1'b0;
            end
            if (pair_in != '0) begin
                zero_reg <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_pulse_single: assert property (
        pair_sample_rate |=> !pair_sample_rate [*7])
        else $error("pair pulse too long or too close");
    a_pulse_period: assert property (
        pair_sample_rate && seen_reg |-> gap_reg == period - 11'h001)
        else $error("pair pulse spacing wrong");
    a_pulse_overdue: assert property (
        seen_reg |-> gap_reg < period)
        else $error("pair pulse overdue");
    a_valid_start: assert property (
        !out_valid |=> out_valid)
        else $error("out_valid late after reset");
    a_valid_hold: assert property (
        out_valid |=> out_valid)
        else $error("out_valid dropped");
    a_out_quiet: assert property (
        !out_valid |-> out_pair == '0)
        else $error("output not zero before valid");
    a_lane_match: assert property (
        same_reg |-> out_pair.i == out_pair.q)
        else $error("lanes differ on equal input");
    a_idle_zero: assert property (
        zero_reg |-> out_pair == '0)
        else $error("output not zero on zero input");
endmodule : iq_chain_properties

bind iq_interpolation_filter_chain iq_chain_properties i_props (
    .clk(clk),
    .rst_n(rst_n),
    .cic_ratio(cic_ratio),
    .optional_halfband_stage(optional_halfband_stage),
    .comb_stage_double_gain(comb_stage_double_gain),
    .pair_in(pair_in),
    .pair_valid(pair_valid),
    .pair_sample_rate(pair_sample_rate),
    .out_pair(out_pair),
    .out_valid(out_valid)
);

// ==== iq_source_model.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// Upstream assembler presenting I/Q pairs
// ------------------------------------------------------------
module iq_source_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control from the bench
    input wire iq_interp_pkg::pair_in_t level,
    input wire logic rand_mode,
    input wire logic valid_req,
    // Towards the chain
    input wire logic pair_sample_rate,
    output iq_interp_pkg::pair_in_t pair_in,
    output logic pair_valid
);
    int seed = 64;           // Fixed seed for repeatable data
    logic took;              // Chain took a pair at the last edge
    logic [1:0] hold_cnt;    // Pulses the current value has stood
    logic signed [11:0] r;   // Fresh random sample

    // Quiet start
    initial begin
        pair_in = '0;
        pair_valid = 1'b0;
        took = 1'b0;
        hold_cnt = 2'h0;
    end

    // Note the take edge
    always @(posedge clk) begin
        took <= pair_sample_rate;
    end

    // Present the next pair after each take
    always @(negedge clk) begin
        pair_valid <= valid_req;
        if (!rst_n) begin
            // Fresh start: no stale unequal pair left from an earlier case
            hold_cnt <= 2'h0;
            pair_in <= rand_mode ? '0 : level;
        end else if (took) begin
            hold_cnt <= hold_cnt + 2'h1;
            if (!rand_mode) begin
                pair_in <= level;
            end else if (hold_cnt == 2'h0) begin
                // Each value stands four pairs: four-times oversampling
                r = 12'($random(seed));
                pair_in <= {r, r};
            end
        end
    end
endmodule : iq_source_model

// ==== test_iq_interpolation_filter_chain.sv ====
`timescale 1ns/1ps

module test_iq_interpolation_filter_chain;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk;
    logic rst_n;
    logic [iq_interp_pkg::RATIO_W-1:0] cic_ratio;
    logic optional_halfband_stage;
    logic comb_stage_double_gain;
    iq_interp_pkg::pair_in_t level;
    iq_interp_pkg::pair_in_t pair_in;
    iq_interp_pkg::pair_out_t out_pair;
    logic rand_mode;
    logic valid_req;
    logic pair_valid;
    logic pair_sample_rate;
    logic out_valid;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int seed = 64;

    iq_interpolation_filter_chain i_dut (
        .clk(clk),
        .rst_n(rst_n),
        .cic_ratio(cic_ratio),
        .optional_halfband_stage(optional_halfband_stage),
        .comb_stage_double_gain(comb_stage_double_gain),
        .pair_in(pair_in),
        .pair_valid(pair_valid),
        .pair_sample_rate(pair_sample_rate),
        .out_pair(out_pair),
        .out_valid(out_valid)
    );

    iq_source_model i_src (
        .clk(clk),
        .rst_n(rst_n),
        .level(level),
        .rand_mode(rand_mode),
        .valid_req(valid_req),
        .pair_sample_rate(pair_sample_rate),
        .pair_in(pair_in),
        .pair_valid(pair_valid)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Clock at 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 100000) begin
            n_errors++;
            wrap_up();
        end
    end

    // Compare within a tolerance
    task automatic check(input logic signed [31:0] seen, input logic signed [31:0] exp,
                         input int tol);
        logic signed [31:0] diff;
        diff = seen - exp;
        n_compared++;
        if (^seen === 1'bx || diff > tol || diff < -tol) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %0d expected %0d", $time, seen, exp);
        end
    endtask : check

    // Settled DC output: 12-bit input at x16, Comb_stage_double_gain R^3/2^s
    function automatic longint exp_dc(input int v, input int r, input bit g);
        longint cube;
        longint y;
        int s;
        cube = longint'(r) * r * r;
        s = 0;
        while ((longint'(1) << s) < cube) s++;
        if (g) s--;
        y = (longint'(v) * 16 * cube) >>> s;
        exp_dc = (y > 32767) ? 32767 : ((y < -32768) ? -32768 : y);
    endfunction : exp_dc

    // Wait for n pulses; gives the spacing of the last two
    task automatic pulses(input int n, output int per);
        int k;
        int c;
        int gap;
        k = 0;
        c = 0;
        gap = 0;
        per = 0;
        while (k < n && c < 40000) begin
            @(negedge clk);
            c++;
            gap++;
            if (pair_sample_rate === 1'b1) begin
                if (k > 0) per = gap;
                gap = 0;
                k++;
            end
        end
    endtask : pulses

    // Reset, configure, settle and check one case
    task automatic run_case(input int r, input bit o, input bit g, input int v,
                            input bit vld, input bit rnd);
        int per;
        int rr;
        logic signed [11:0] vi;
        logic signed [11:0] vq;
        @(negedge clk);
        rst_n = 1'b0;
        vi = 12'(v);
        vq = ~vi;
        cic_ratio = 6'(r);
        optional_halfband_stage = o;
        comb_stage_double_gain = g;
        level = {vi, vq};
        valid_req = vld;
        rand_mode = rnd;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        rr = (r < 2) ? 2 : r;
        pulses(40, per);
        check(per, (o ? 8 : 4) * rr, 0);
        repeat (32) begin
            @(negedge clk);
            if (rnd) begin
                check(out_pair.i, out_pair.q, 0);
            end else begin
                check(out_pair.i, vld ? exp_dc(vi, rr, g) : 0, 4);
                check(out_pair.q, vld ? exp_dc(vq, rr, g) : 0, 4);
            end
        end
        $display("Test done: ratio %0d opt %0d gain %0d value %0d", r, o, g, v);
    endtask : run_case

    // Verdict
    task automatic wrap_up;
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        cic_ratio = 6'h02;
        optional_halfband_stage = 1'b0;
        comb_stage_double_gain = 1'b0;
        level = '0;
        rand_mode = 1'b0;
        valid_req = 1'b0;
        // Corner cases
        run_case(2, 1'b0, 1'b0, 300, 1'b1, 1'b0);
        run_case(0, 1'b1, 1'b0, -500, 1'b1, 1'b0);
        run_case(3, 1'b0, 1'b0, 700, 1'b1, 1'b0);
        // Doubled gain at ratios 5 and 4, then ratio 63 and a missing pair
        run_case(5, 1'b1, 1'b1, 400, 1'b1, 1'b0);
        run_case(4, 1'b0, 1'b1, 1023, 1'b1, 1'b0);
        run_case(63, 1'b0, 1'b0, -2048, 1'b1, 1'b0);
        run_case(7, 1'b0, 1'b0, 300, 1'b0, 1'b0);
        // Random configurations
        repeat (4) begin
            run_case(2 + (($random(seed) & 32'h7FFFFFFF) % 11), 1'($random(seed)), 1'b0,
                     ($random(seed) % 1500), 1'b1, 1'b0);
        end
        // Random data through both lanes, optional stage kept on
        run_case(2, 1'b1, 1'b0, 0, 1'b1, 1'b1);
        wrap_up();
    end
endmodule : test_iq_interpolation_filter_chain
